/* core/cbc_pkg.sv */
// Shared constants and types of the bus control and address generation block.
package cbc_pkg;

   // ****************************************
   // Address map and vectors
   // ****************************************
   localparam logic [15:0] PORT_DIR_ADDR = 16'h0000;
   localparam logic [15:0] PORT_OUT_ADDR = 16'h0001;
   localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
   localparam logic [15:0] VEC_IRQ_LO = 16'hFFFE;
   localparam logic [7:0] STACK_PAGE = 8'h01;
   localparam logic [7:0] ZERO_PAGE = 8'h00;

   // ****************************************
   // Reset values and field positions
   // ****************************************
   localparam logic [7:0] PORT_DIR_RESET = 8'h00;
   localparam logic [7:0] PORT_OUT_RESET = 8'h00;
   localparam logic [7:0] SP_RESET = 8'hFF;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int MASK_BIT = 2;

   // ****************************************
   // Timing counts
   // ****************************************
   localparam logic [2:0] INIT_CYCLES = 3'h6;
   localparam int RESET_MIN_CYCLES = 2;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      MD_ACC, MD_IMPL, MD_IMM, MD_ABS, MD_ZP, MD_ZP_IDX, MD_ABS_IDX, MD_REL, MD_IDX_IND
   } cbc_mode_t;

   typedef enum logic [1:0] {
      MK_NONE, MK_SET, MK_CLEAR
   } cbc_mask_op_t;

   typedef struct packed {
      cbc_mode_t mode;
      logic use_y;
      logic write;
      logic taken;
      cbc_mask_op_t mask_op;
      logic [1:0] len;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] wdata;
   } cbc_op_t;

   typedef struct packed {
      logic [15:0] addr;
      logic rw;
      logic [7:0] wdata;
   } cbc_bus_t;

endpackage

/* core/cbc_core.sv */
// Bus sequencer, reset and interrupt entry, peripheral port and address modes.
`timescale 1ns/100ps
module cbc_core
   import cbc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Bus pins
   output logic [15:0] address_lines,
   output logic [15:0] address_oe,
   input wire logic address_bus_enable,
   input wire logic [7:0] data_lines_in,
   output logic [7:0] data_lines_out,
   output logic data_lines_oe,
   output logic read_not_write,
   input wire logic irq_n,
   // Peripheral port pins
   input wire logic [7:0] peripheral_port_pins_in,
   output logic [7:0] peripheral_port_pins_out,
   output logic [7:0] peripheral_port_pins_oe,
   // Operation port from the instruction sequencer
   input wire logic op_valid,
   output logic op_ready,
   input wire cbc_op_t op_in,
   input wire logic [7:0] index_x,
   input wire logic [7:0] index_y,
   input wire logic [7:0] status_flags,
   output logic op_done,
   output logic [7:0] op_rdata,
   output logic [15:0] pc,
   output logic mask_flag
);

   // ****************************************
   // Declarations
   // ****************************************
   typedef enum logic [3:0] {
      S_INIT, S_VEC_LO, S_VEC_HI, S_IDLE, S_PTR_LO, S_PTR_HI, S_ACCESS,
      S_PUSH_HI, S_PUSH_LO, S_PUSH_P
   } cbc_state_t;

   cbc_state_t state_r, state_nxt;
   cbc_bus_t bus_r, bus_nxt;
   cbc_op_t op_r, cur_op;
   logic [2:0] init_cnt_r;
   logic [7:0] sp_r, zp_r, ptr_lo_r, dir_r, out_r, status_r, rdata_r;
   logic [15:0] pc_r, pc_fin;
   logic vec_irq_r, done_r;
   logic [2:0] irq_sync_r;
   logic irq_lvl_r;
   logic [7:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
   logic irq_take, accept, finish, port_rd_hit;
   logic [7:0] rd_val;

   function automatic logic needs_bus(input cbc_mode_t m);
      needs_bus = (m == MD_ABS) || (m == MD_ZP) || (m == MD_ZP_IDX) ||
                  (m == MD_ABS_IDX) || (m == MD_IDX_IND);
   endfunction

   function automatic logic [15:0] direct_ea(input cbc_op_t o, input logic [7:0] idx);
      unique case (o.mode)
         MD_ZP: direct_ea = {ZERO_PAGE, o.b2};
         MD_ZP_IDX: direct_ea = {ZERO_PAGE, 8'(o.b2 + idx)};
         MD_ABS_IDX: direct_ea = 16'({o.b3, o.b2} + {8'h00, idx});
         default: direct_ea = {o.b3, o.b2};
      endcase
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // A change counts only once the second and third stages agree.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_sync_r <= 3'h7;
         irq_lvl_r <= 1'b0;
      end else begin
         irq_sync_r <= {irq_sync_r[1:0], irq_n};
         if (irq_sync_r[1] == irq_sync_r[2]) begin
            irq_lvl_r <= ~irq_sync_r[2];
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_r <= 8'h00;
         pin_s2_r <= 8'h00;
         pin_s3_r <= 8'h00;
         pin_r <= 8'h00;
      end else begin
         pin_s1_r <= peripheral_port_pins_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_r <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r ^ pin_s3_r));
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   assign cur_op = (state_r == S_IDLE) ? op_in : op_r;
   assign irq_take = (state_r == S_IDLE) && irq_lvl_r && !status_r[MASK_BIT];
   assign op_ready = (state_r == S_IDLE) && !irq_take;
   assign accept = op_valid && op_ready;
   // Accumulator, implied, immediate and branch operations finish with no bus cycle.
   assign finish = (accept && !needs_bus(op_in.mode)) || (state_r == S_ACCESS);
   // The counter first steps past the instruction, then a taken branch adds the offset.
   assign pc_fin = 16'(pc_r + {14'h0000, cur_op.len} +
                 ((cur_op.mode == MD_REL && cur_op.taken) ?
                  {{8{cur_op.b2[7]}}, cur_op.b2} : 16'h0000));

   always_comb begin
      state_nxt = state_r;
      bus_nxt = '{addr: pc_r, rw: 1'b1, wdata: 8'h00};
      unique case (state_r)
         S_INIT: begin
            if (init_cnt_r == INIT_CYCLES - 3'h1) begin
               state_nxt = S_VEC_LO;
               bus_nxt.addr = VEC_RESET_LO;
            end
         end
         S_VEC_LO: begin
            state_nxt = S_VEC_HI;
            bus_nxt.addr = bus_r.addr + 16'h0001;
         end
         S_VEC_HI: state_nxt = S_IDLE;
         S_IDLE: begin
            if (irq_take) begin
               state_nxt = S_PUSH_HI;
               bus_nxt = '{addr: {STACK_PAGE, sp_r}, rw: 1'b0, wdata: pc_r[15:8]};
            end else if (accept && op_in.mode == MD_IDX_IND) begin
               state_nxt = S_PTR_LO;
               bus_nxt.addr = {ZERO_PAGE, 8'(op_in.b2 + index_x)};
            end else if (accept && needs_bus(op_in.mode)) begin
               state_nxt = S_ACCESS;
               bus_nxt = '{addr: direct_ea(op_in, op_in.use_y ? index_y : index_x),
                           rw: !op_in.write, wdata: op_in.wdata};
            end
         end
         S_PTR_LO: begin
            state_nxt = S_PTR_HI;
            bus_nxt.addr = {ZERO_PAGE, 8'(zp_r + 8'h01)};
         end
         S_PTR_HI: begin
            state_nxt = S_ACCESS;
            bus_nxt = '{addr: {data_lines_in, ptr_lo_r}, rw: !op_r.write, wdata: op_r.wdata};
         end
         S_ACCESS: state_nxt = S_IDLE;
         S_PUSH_HI: begin
            state_nxt = S_PUSH_LO;
            bus_nxt = '{addr: {STACK_PAGE, sp_r}, rw: 1'b0, wdata: pc_r[7:0]};
         end
         S_PUSH_LO: begin
            state_nxt = S_PUSH_P;
            bus_nxt = '{addr: {STACK_PAGE, sp_r}, rw: 1'b0, wdata: status_flags};
            bus_nxt.wdata[MASK_BIT] = status_r[MASK_BIT];
         end
         S_PUSH_P: begin
            state_nxt = S_VEC_LO;
            bus_nxt.addr = VEC_IRQ_LO;
         end
      endcase
   end

   // Reset forces a read cycle, so nothing can be written while it is held.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_INIT;
         bus_r <= '{addr: 16'h0000, rw: 1'b1, wdata: 8'h00};
      end else begin
         state_r <= state_nxt;
         bus_r <= bus_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         init_cnt_r <= 3'h0;
      end else if (state_r == S_INIT) begin
         init_cnt_r <= init_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         op_r <= '0;
         zp_r <= 8'h00;
         ptr_lo_r <= 8'h00;
      end else begin
         if (accept) begin
            op_r <= op_in;
            zp_r <= 8'(op_in.b2 + index_x);
         end
         if (state_r == S_PTR_LO) begin
            ptr_lo_r <= data_lines_in;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sp_r <= SP_RESET;
         vec_irq_r <= 1'b0;
      end else begin
         if (state_nxt == S_PUSH_HI || state_nxt == S_PUSH_LO || state_nxt == S_PUSH_P) begin
            sp_r <= sp_r - 8'h01;
         end
         if (irq_take) begin
            vec_irq_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // Program counter and mask flag
   // ****************************************
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pc_r <= 16'h0000;
      end else if (state_r == S_VEC_LO) begin
         pc_r[7:0] <= data_lines_in;
      end else if (state_r == S_VEC_HI) begin
         pc_r[15:8] <= data_lines_in;
      end else if (finish) begin
         pc_r <= pc_fin;
      end
   end

   // Hardware sets win over a clear issued by the operation in the same cycle.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status_r <= STATUS_RESET;
      end else if (state_nxt == S_VEC_LO) begin
         status_r[MASK_BIT] <= 1'b1;
      end else if (finish && cur_op.mask_op == MK_SET) begin
         status_r[MASK_BIT] <= 1'b1;
      end else if (finish && cur_op.mask_op == MK_CLEAR) begin
         status_r[MASK_BIT] <= 1'b0;
      end
   end

   // ****************************************
   // Peripheral port and operation result
   // ****************************************
   // The internal registers answer reads at their addresses; the external cycle still runs.
   assign port_rd_hit = (bus_r.addr == PORT_DIR_ADDR) || (bus_r.addr == PORT_OUT_ADDR);
   assign rd_val = (bus_r.addr == PORT_DIR_ADDR) ? dir_r :
                   (bus_r.addr == PORT_OUT_ADDR) ? ((out_r & dir_r) | (pin_r & ~dir_r)) :
                   data_lines_in;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dir_r <= PORT_DIR_RESET;
         out_r <= PORT_OUT_RESET;
      end else if (state_r == S_ACCESS && !bus_r.rw) begin
         if (bus_r.addr == PORT_DIR_ADDR) begin
            dir_r <= bus_r.wdata;
         end
         if (bus_r.addr == PORT_OUT_ADDR) begin
            out_r <= bus_r.wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         done_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         done_r <= finish;
         if (accept && op_in.mode == MD_IMM) begin
            rdata_r <= op_in.b2;
         end else if (state_r == S_ACCESS && bus_r.rw) begin
            rdata_r <= port_rd_hit ? rd_val : data_lines_in;
         end
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   assign address_lines = bus_r.addr;
   assign address_oe = {16{address_bus_enable}};
   assign read_not_write = bus_r.rw;
   assign data_lines_out = bus_r.wdata;
   assign data_lines_oe = !bus_r.rw;
   assign peripheral_port_pins_out = out_r;
   assign peripheral_port_pins_oe = dir_r;
   assign op_done = done_r;
   assign op_rdata = rdata_r;
   assign pc = pc_r;
   assign mask_flag = status_r[MASK_BIT];

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   AST_INIT_VECTOR: assert property ((state_r == S_INIT && init_cnt_r == 3'h0) |-> ##6
      (state_r == S_VEC_LO && bus_r.addr == VEC_RESET_LO && mask_flag))
      else $error("Reset vector fetch not after six init cycles.");
   AST_NO_WRITE_IN_INIT: assert property ((state_r == S_INIT) |-> read_not_write)
      else $error("Write cycle during reset sequence.");
   AST_VECTOR_PAIR: assert property ((state_r == S_VEC_LO) |=>
      (state_r == S_VEC_HI && bus_r.addr == 16'($past(bus_r.addr) + 16'h0001)))
      else $error("Vector high byte not fetched from next address.");
   AST_IRQ_AT_BOUNDARY: assert property ((state_r == S_PUSH_HI && $past(state_r) != S_PUSH_P)
      |-> ($past(state_r) == S_IDLE && !$past(mask_flag)))
      else $error("Interrupt entered inside an operation or while masked.");
   AST_PUSH_ORDER: assert property ((state_r == S_PUSH_HI) |->
      (data_lines_out == pc_r[15:8] && !read_not_write) ##1
      (data_lines_out == pc_r[7:0] && state_r == S_PUSH_LO) ##1
      (state_r == S_PUSH_P && !read_not_write))
      else $error("Stack push order wrong.");
   AST_IRQ_MASK_VEC: assert property ((state_r == S_PUSH_P) |=>
      (mask_flag && state_r == S_VEC_LO && address_lines == VEC_IRQ_LO))
      else $error("Interrupt entry did not set mask or fetch vector.");
   AST_ADDR_ENABLE: assert property (address_oe == {16{address_bus_enable}})
      else $error("Address drive not following address bus enable.");
   AST_RW_ONLY_WRITE: assert property (!read_not_write |->
      (state_r inside {S_ACCESS, S_PUSH_HI, S_PUSH_LO, S_PUSH_P} && data_lines_oe))
      else $error("Write cycle outside a write state.");
   AST_ZP_WRAP: assert property ((accept && op_in.mode inside {MD_ZP, MD_ZP_IDX})
      |=> (address_lines[15:8] == ZERO_PAGE))
      else $error("Zero page access left page zero.");
   AST_BRANCH: assert property ((accept && op_in.mode == MD_REL) |=>
      (pc_r == 16'($past(pc_r) + {14'h0000, $past(op_in.len)} +
       ($past(op_in.taken) ? {{8{$past(op_in.b2[7])}}, $past(op_in.b2)} : 16'h0000))))
      else $error("Branch target wrong.");
   AST_PORT_DIR: assert property ((state_r == S_ACCESS && !read_not_write &&
      address_lines == PORT_DIR_ADDR) |=> (peripheral_port_pins_oe == $past(data_lines_out)))
      else $error("Port direction write lost.");

   COV_RESET_FETCH: cover property (state_r == S_VEC_HI ##1 state_r == S_IDLE);
   COV_IRQ_ENTRY: cover property (state_r == S_PUSH_P ##1 state_r == S_VEC_LO);
   COV_INDIRECT: cover property (state_r == S_PTR_HI ##1 state_r == S_ACCESS);
   COV_BRANCH_BACK: cover property (accept && op_in.mode == MD_REL && op_in.taken && op_in.b2[7]);

endmodule

/* verification/cbc_mem_model.sv */
// Memory and peripheral model on the far side of the processor bus.
`timescale 1ns/100ps
module cbc_mem_model (
   // Clock
   input wire logic core_clk,
   // Bus from the processor
   input wire logic [15:0] address_lines,
   input wire logic [15:0] address_oe,
   input wire logic read_not_write,
   input wire logic data_lines_oe,
   input wire logic [7:0] data_lines_out,
   // Data wire level seen by the processor
   output logic [7:0] data_lines_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_r = 8'h00;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'(i >> 8);
      end
      mem[16'hFFFC] = 8'h34;
      mem[16'hFFFD] = 8'h12;
      mem[16'hFFFE] = 8'hCD;
      mem[16'hFFFF] = 8'hAB;
   end

   // A released address bus selects nothing, so the wire shows a changing pattern, not old data.
   assign data_lines_in = data_lines_oe ? data_lines_out :
      ((&address_oe) ? mem[address_lines] : ~last_r);

   always @(posedge core_clk) begin
      last_r <= data_lines_in;
      if ((&address_oe) && !read_not_write && data_lines_oe) begin
         mem[address_lines] <= data_lines_out;
      end
   end
endmodule

/* verification/tb_cpu_bus_control_and_address_modes.sv */
// Self-checking testbench of the bus control and address generation block.
`timescale 1ns/100ps
module tb_cpu_bus_control_and_address_modes
   import cbc_pkg::*;
;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic address_bus_enable = 1'b1;
   logic irq_n = 1'b1;
   logic op_valid = 1'b0;
   logic [7:0] peripheral_port_pins_in = 8'h3C;
   logic [7:0] index_x = 8'h00;
   logic [7:0] index_y = 8'h00;
   logic [7:0] status_flags = 8'hC7;
   cbc_op_t op_in = '0;
   wire logic [15:0] address_lines, address_oe, pc;
   wire logic [7:0] data_lines_in, data_lines_out, op_rdata;
   wire logic [7:0] peripheral_port_pins_out, peripheral_port_pins_oe;
   wire logic data_lines_oe, read_not_write, op_ready, op_done, mask_flag;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int bus_n;
   logic [15:0] last_a, pc0, ret;
   logic saw_w;

   cbc_core cbc_core_inst (.core_clk(core_clk), .resetn(resetn),
      .address_lines(address_lines), .address_oe(address_oe),
      .address_bus_enable(address_bus_enable), .data_lines_in(data_lines_in),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
      .read_not_write(read_not_write), .irq_n(irq_n),
      .peripheral_port_pins_in(peripheral_port_pins_in),
      .peripheral_port_pins_out(peripheral_port_pins_out),
      .peripheral_port_pins_oe(peripheral_port_pins_oe), .op_valid(op_valid),
      .op_ready(op_ready), .op_in(op_in), .index_x(index_x), .index_y(index_y),
      .status_flags(status_flags), .op_done(op_done), .op_rdata(op_rdata), .pc(pc),
      .mask_flag(mask_flag));

   cbc_mem_model cbc_mem_model_inst (.core_clk(core_clk), .address_lines(address_lines),
      .address_oe(address_oe), .read_not_write(read_not_write),
      .data_lines_oe(data_lines_oe), .data_lines_out(data_lines_out),
      .data_lines_in(data_lines_in));

   // ****************************************
   // Clock, timeout and shared tasks
   // ****************************************
   // One clock stands in for both non-overlapping phases.
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   initial begin
      forever begin
         @(posedge core_clk);
         cycles++;
         if (cycles == 20000) begin
            num_errors++;
            wrap_up();
         end
      end
   end

   task automatic wrap_up();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Flags f: write, use_y, taken, mask operation (two bits).
   task automatic run(input cbc_mode_t m, input logic [1:0] ln, input logic [7:0] b2,
      input logic [7:0] b3 = 8'h00, input logic [4:0] f = 5'h00, input logic [7:0] wd = 8'h00);
      int n;
      @(negedge core_clk);
      pc0 = pc;
      op_in = '{mode: m, use_y: f[3], write: f[4], taken: f[2],
         mask_op: cbc_mask_op_t'(f[1:0]), len: ln, b2: b2, b3: b3, wdata: wd};
      op_valid = 1'b1;
      n = 0;
      while (op_ready !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      op_valid = 1'b0;
      bus_n = 0;
      saw_w = 1'b0;
      while (op_done !== 1'b1 && bus_n < 20) begin
         last_a = address_lines;
         saw_w = saw_w | (read_not_write === 1'b0);
         bus_n++;
         @(negedge core_clk);
      end
      check(op_done, 1'b1);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic s_reset(input int hold);
      int n;
      repeat (hold) begin
         @(negedge core_clk);
         check(read_not_write, 1'b1);
         check(data_lines_oe, 1'b0);
      end
      resetn = 1'b1;
      n = 0;
      while (address_lines !== VEC_RESET_LO && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      check(16'(n), 16'h0006);
      @(negedge core_clk);
      check(address_lines, 16'hFFFD);
      n = 0;
      while (op_ready !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      check(pc, 16'h1234);
      check(mask_flag, 1'b1);
   endtask

   task automatic s_modes();
      index_x = 8'h20;
      index_y = 8'h40;
      run(MD_ACC, 2'h1, 8'h00);
      check(16'(bus_n), 16'h0000);
      run(MD_IMPL, 2'h1, 8'h00);
      check(16'(bus_n), 16'h0000);
      run(MD_IMM, 2'h2, 8'h9C);
      check(16'(bus_n), 16'h0000);
      check(op_rdata, 8'h9C);
      run(MD_ABS, 2'h3, 8'h34, 8'h12);
      check(last_a, 16'h1234);
      check(op_rdata, cbc_mem_model_inst.mem[16'h1234]);
      check(saw_w, 1'b0);
      run(MD_ZP, 2'h2, 8'h77, 8'h55);
      check(last_a, 16'h0077);
      check(16'(bus_n), 16'h0001);
      run(MD_ZP_IDX, 2'h2, 8'hF0);
      check(last_a, 16'h0010);
      run(MD_ZP_IDX, 2'h2, 8'hF0, 8'h00, 5'h08);
      check(last_a, 16'h0030);
      run(MD_ABS_IDX, 2'h3, 8'hF0, 8'h12);
      check(last_a, 16'h1310);
      run(MD_ABS_IDX, 2'h3, 8'hF0, 8'hFF, 5'h08);
      check(last_a, 16'h0030);
      check(op_rdata, cbc_mem_model_inst.mem[16'h0030]);
   endtask

   task automatic s_write_port();
      run(MD_ABS, 2'h3, 8'h45, 8'h23, 5'h10, 8'hA5);
      check(saw_w, 1'b1);
      check(cbc_mem_model_inst.mem[16'h2345], 8'hA5);
      run(MD_ABS, 2'h3, 8'h00, 8'h00, 5'h10, 8'hF0);
      run(MD_ABS, 2'h3, 8'h01, 8'h00, 5'h10, 8'hA5);
      check(peripheral_port_pins_oe, 8'hF0);
      check(peripheral_port_pins_out, 8'hA5);
      run(MD_ABS, 2'h3, 8'h01, 8'h00);
      check(op_rdata, 8'hAC);
      run(MD_ZP, 2'h2, 8'h00);
      check(op_rdata, 8'hF0);
      address_bus_enable = 1'b0;
      @(negedge core_clk);
      check(address_oe, 16'h0000);
      address_bus_enable = 1'b1;
      @(negedge core_clk);
      check(address_oe, 16'hFFFF);
   endtask

   task automatic s_branch();
      run(MD_REL, 2'h2, 8'h80, 8'h00, 5'h04);
      @(negedge core_clk);
      check(pc, pc0 + 16'hFF82);
      run(MD_REL, 2'h2, 8'h7F, 8'h00, 5'h04);
      @(negedge core_clk);
      check(pc, pc0 + 16'h0081);
      run(MD_REL, 2'h2, 8'h80);
      @(negedge core_clk);
      check(pc, pc0 + 16'h0002);
   endtask

   task automatic s_irq();
      int n;
      run(MD_IMPL, 2'h1, 8'h00, 8'h00, 5'h02);
      check(mask_flag, 1'b0);
      run(MD_IMPL, 2'h1, 8'h00, 8'h00, 5'h01);
      check(mask_flag, 1'b1);
      run(MD_IMPL, 2'h1, 8'h00, 8'h00, 5'h02);
      check(mask_flag, 1'b0);
      index_x = 8'h1E;
      cbc_mem_model_inst.mem[16'h000E] = 8'h78;
      cbc_mem_model_inst.mem[16'h000F] = 8'h56;
      irq_n = 1'b0;
      run(MD_IDX_IND, 2'h2, 8'hF0);
      ret = pc0 + 16'h0002;
      check(16'(bus_n), 16'h0003);
      check(last_a, 16'h5678);
      check(op_rdata, cbc_mem_model_inst.mem[16'h5678]);
      n = 0;
      while (pc !== 16'hABCD && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      check(pc, 16'hABCD);
      check(cbc_mem_model_inst.mem[16'h01FF], ret[15:8]);
      check(cbc_mem_model_inst.mem[16'h01FE], ret[7:0]);
      // The pushed status carries the mask bit as it stood at entry (clear), not the input's.
      check(cbc_mem_model_inst.mem[16'h01FD], 8'hC3);
      check(mask_flag, 1'b1);
      repeat (12) @(negedge core_clk);
      check(pc, 16'hABCD);
      check(op_ready, 1'b1);
      irq_n = 1'b1;
   endtask

   // Reset dropped in the middle of a write cycle must cancel the write at once.
   task automatic s_mid_reset();
      @(negedge core_clk);
      op_in = '{mode: MD_ABS, use_y: 1'b0, write: 1'b1, taken: 1'b0, mask_op: MK_NONE,
         len: 2'h3, b2: 8'h67, b3: 8'h45, wdata: 8'h5A};
      op_valid = 1'b1;
      @(negedge core_clk);
      op_valid = 1'b0;
      check(read_not_write, 1'b0);
      check(address_lines, 16'h4567);
      resetn = 1'b0;
      #1;
      check(read_not_write, 1'b1);
      check(data_lines_oe, 1'b0);
      check(peripheral_port_pins_oe, PORT_DIR_RESET);
      s_reset(2);
      check(cbc_mem_model_inst.mem[16'h4567], 8'h22);
   endtask

   initial begin
      s_reset(10);
      s_modes();
      s_write_port();
      s_branch();
      s_irq();
      s_mid_reset();
      wrap_up();
   end
endmodule
